/* File: common/sfpst_regs.svh */
// timing constants for the serial flash power-state sequencer
`ifndef SFPST_REGS_SVH
`define SFPST_REGS_SVH
`define SFPST_CLK_PERIOD_PS 4000
`define SFPST_ULTRA_SLEEP_ENTRY_DELAY_NS 3000
`define SFPST_WAKE_PULSE_MIN_WIDTH_NS 20
`define SFPST_ULTRA_SLEEP_EXIT_RECOVERY_NS 70000
`define SFPST_RESUME_TO_STANDBY_DELAY_NS 8000
`define SFPST_SECURE_AREA_PROGRAM_TIME_NS 950000
`define SFPST_SECURE_AREA_PROGRAM_TYP_NS 400000
`define SFPST_CONFIG_WORD_WRITE_TIME_NS 200
`define SFPST_SUPPLY_TO_FIRST_READ_DELAY_NS 70000
`define SFPST_POWERUP_WRITE_LOCKOUT_DELAY_NS 3000000
`define SFPST_PAGE_PROGRAM_TIME_NS 2500000
`define SFPST_PAGE_ERASE_TIME_NS 20000000
`define SFPST_BLOCK64_ERASE_TIME_NS 1000000000
`define SFPST_CHIP_ERASE_TIME_US 4000000
// cycle counts: least times round up, longest times round down
// 64-bit arithmetic: millisecond figures overflow a 32-bit int once scaled to ps
`define SFPST_CYC_MAX(ns) ((64'd1000 * (ns)) / `SFPST_CLK_PERIOD_PS)
`define SFPST_CYC_MIN(ns) (((64'd1000 * (ns)) + `SFPST_CLK_PERIOD_PS - 1) / `SFPST_CLK_PERIOD_PS)
`define SFPST_ENTRY_CYC `SFPST_CYC_MAX(`SFPST_ULTRA_SLEEP_ENTRY_DELAY_NS)
`define SFPST_WAKE_CYC `SFPST_CYC_MIN(`SFPST_WAKE_PULSE_MIN_WIDTH_NS)
`define SFPST_EXIT_CYC `SFPST_CYC_MIN(`SFPST_ULTRA_SLEEP_EXIT_RECOVERY_NS)
`define SFPST_RESUME_CYC `SFPST_CYC_MAX(`SFPST_RESUME_TO_STANDBY_DELAY_NS)
`define SFPST_OTP_CYC `SFPST_CYC_MAX(`SFPST_SECURE_AREA_PROGRAM_TIME_NS)
`define SFPST_CFGW_CYC `SFPST_CYC_MAX(`SFPST_CONFIG_WORD_WRITE_TIME_NS)
`define SFPST_READ_LOCK_CYC `SFPST_CYC_MIN(`SFPST_SUPPLY_TO_FIRST_READ_DELAY_NS)
`define SFPST_PUW_CYC `SFPST_CYC_MAX(`SFPST_POWERUP_WRITE_LOCKOUT_DELAY_NS)
`define SFPST_PP_CYC `SFPST_CYC_MAX(`SFPST_PAGE_PROGRAM_TIME_NS)
`define SFPST_PE_CYC `SFPST_CYC_MAX(`SFPST_PAGE_ERASE_TIME_NS)
`define SFPST_BE_CYC (64'd`SFPST_BLOCK64_ERASE_TIME_NS * 64'd1000 / 64'd`SFPST_CLK_PERIOD_PS)
`define SFPST_CE_CYC (64'd`SFPST_CHIP_ERASE_TIME_US * 64'd1000000 / 64'd`SFPST_CLK_PERIOD_PS)
`endif

/* File: common/sfpst_pkg.sv */
// types for the serial flash power-state sequencer
package sfpst_pkg;
  typedef enum logic [2:0] {
    SFPST_ST_POR = 3'h0,
    SFPST_ST_STANDBY = 3'h1,
    SFPST_ST_ACTIVE = 3'h2,
    SFPST_ST_BUSY = 3'h3,
    SFPST_ST_ENTER_ULTRA = 3'h4,
    SFPST_ST_ULTRA = 3'h5,
    SFPST_ST_EXIT_ULTRA = 3'h6,
    SFPST_ST_RESUME = 3'h7
  } sfpst_state_e;
  typedef enum logic [2:0] {
    SFPST_OP_NONE = 3'h0,
    SFPST_OP_PAGE_PROG = 3'h1,
    SFPST_OP_PAGE_ERASE = 3'h2,
    SFPST_OP_BLOCK_ERASE = 3'h3,
    SFPST_OP_CHIP_ERASE = 3'h4,
    SFPST_OP_OTP_PROG = 3'h5,
    SFPST_OP_CFG_WRITE = 3'h6,
    SFPST_OP_RESUME = 3'h7
  } sfpst_op_e;
  typedef logic [39:0] sfpst_cnt_t;
endpackage

/* File: design/sfpst_core.sv */
// power-state and operation timing sequencer of a small serial flash
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/100ps
`include "sfpst_regs.svh"
module sfpst_core
  import sfpst_pkg::*;
#(
  parameter sfpst_cnt_t ENTRY_CYC = sfpst_cnt_t'(`SFPST_ENTRY_CYC),
  parameter sfpst_cnt_t EXIT_CYC = sfpst_cnt_t'(`SFPST_EXIT_CYC),
  parameter sfpst_cnt_t RESUME_CYC = sfpst_cnt_t'(`SFPST_RESUME_CYC),
  parameter sfpst_cnt_t OTP_CYC = sfpst_cnt_t'(`SFPST_OTP_CYC),
  parameter sfpst_cnt_t READ_LOCK_CYC = sfpst_cnt_t'(`SFPST_READ_LOCK_CYC),
  parameter sfpst_cnt_t PUW_CYC = sfpst_cnt_t'(`SFPST_PUW_CYC),
  parameter sfpst_cnt_t PP_CYC = sfpst_cnt_t'(`SFPST_PP_CYC),
  parameter sfpst_cnt_t PE_CYC = sfpst_cnt_t'(`SFPST_PE_CYC),
  parameter sfpst_cnt_t BE_CYC = sfpst_cnt_t'(`SFPST_BE_CYC),
  parameter sfpst_cnt_t CE_CYC = sfpst_cnt_t'(`SFPST_CE_CYC)
) (
  // clock and reset (srst models the internal power-on reset)
  input wire logic mclk,
  input wire logic srst,
  // serial link pins
  input wire logic chip_select_n,
  input wire logic sclk,
  input wire logic so_drive_req,
  output logic so_oe,
  // decoded command from the command layer, pulsed at chip select rise
  input wire logic cmd_valid,
  input wire sfpst_op_e cmd_op,
  input wire logic cmd_ultra_sleep,
  input wire logic cmd_is_read,
  // status
  output sfpst_state_e state,
  output logic spi_mode3,
  output logic cmd_accept,
  output logic busy,
  output logic read_allowed,
  output logic write_allowed
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic cs_m_q, cs_s_q, cs_d_q;
  logic clk_m_q, clk_s_q;
  always_ff @(posedge mclk) begin
    if (srst) begin
      cs_m_q <= 1'b1;
      cs_s_q <= 1'b1;
      cs_d_q <= 1'b1;
      clk_m_q <= 1'b0;
      clk_s_q <= 1'b0;
    end else begin
      cs_m_q <= chip_select_n;
      cs_s_q <= cs_m_q;
      cs_d_q <= cs_s_q;
      clk_m_q <= sclk;
      clk_s_q <= clk_m_q;
    end
  end
  logic cs_fall, cs_rise;
  assign cs_fall = cs_d_q & ~cs_s_q;
  assign cs_rise = ~cs_d_q & cs_s_q;

  // ----------------------------------------------------------------
  // timing helpers
  // ----------------------------------------------------------------
  function automatic sfpst_cnt_t op_cycles(input sfpst_op_e op);
    case (op)
      SFPST_OP_PAGE_PROG: op_cycles = PP_CYC;
      SFPST_OP_PAGE_ERASE: op_cycles = PE_CYC;
      SFPST_OP_BLOCK_ERASE: op_cycles = BE_CYC;
      SFPST_OP_CHIP_ERASE: op_cycles = CE_CYC;
      SFPST_OP_OTP_PROG: op_cycles = OTP_CYC;
      SFPST_OP_CFG_WRITE: op_cycles = sfpst_cnt_t'(`SFPST_CFGW_CYC);
      default: op_cycles = sfpst_cnt_t'(1);
    endcase
  endfunction

  function automatic logic is_write(input sfpst_op_e op);
    is_write = (op != SFPST_OP_NONE) && (op != SFPST_OP_RESUME);
  endfunction

  // ----------------------------------------------------------------
  // power-up lockout counters
  // ----------------------------------------------------------------
  sfpst_cnt_t pu_cnt_q;
  logic puw_done_q, rd_done_q;
  always_ff @(posedge mclk) begin
    if (srst) begin
      pu_cnt_q <= '0;
      puw_done_q <= 1'b0;
      rd_done_q <= 1'b0;
    end else begin
      if (!puw_done_q) begin
        pu_cnt_q <= pu_cnt_q + sfpst_cnt_t'(1);
      end
      if (pu_cnt_q + sfpst_cnt_t'(1) >= READ_LOCK_CYC) begin
        rd_done_q <= 1'b1;
      end
      if (pu_cnt_q + sfpst_cnt_t'(1) >= PUW_CYC) begin
        puw_done_q <= 1'b1;
      end
    end
  end
  assign read_allowed = rd_done_q;
  assign write_allowed = puw_done_q;

  // ----------------------------------------------------------------
  // mode selection, sampled at every chip select fall
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      spi_mode3 <= 1'b0;
    end else if (cs_fall) begin
      spi_mode3 <= clk_s_q;
    end
  end

  // ----------------------------------------------------------------
  // power-state machine
  // ----------------------------------------------------------------
  sfpst_state_e state_q;
  sfpst_cnt_t tmr_q;
  logic armed_q;
  logic accept_now;
  // a command counts only if the frame began with a fall seen in standby or active
  assign accept_now = cmd_valid & cs_rise & armed_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      armed_q <= 1'b0;
    end else if (cs_fall) begin
      armed_q <= (state_q == SFPST_ST_STANDBY) || (state_q == SFPST_ST_ACTIVE);
    end else if (cs_rise) begin
      armed_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= SFPST_ST_POR;
      tmr_q <= '0;
    end else begin
      case (state_q)
        SFPST_ST_POR: begin
          // leave power-up once the write lockout has expired
          if (puw_done_q) begin
            state_q <= cs_s_q ? SFPST_ST_STANDBY : SFPST_ST_ACTIVE;
          end
        end
        SFPST_ST_STANDBY, SFPST_ST_ACTIVE: begin
          if (accept_now && cmd_ultra_sleep) begin
            state_q <= SFPST_ST_ENTER_ULTRA;
            tmr_q <= ENTRY_CYC;
          end else if (accept_now && cmd_op == SFPST_OP_RESUME) begin
            state_q <= SFPST_ST_RESUME;
            tmr_q <= RESUME_CYC;
          end else if (accept_now && is_write(cmd_op) && puw_done_q) begin
            state_q <= SFPST_ST_BUSY;
            tmr_q <= op_cycles(cmd_op);
          end else begin
            state_q <= cs_s_q ? SFPST_ST_STANDBY : SFPST_ST_ACTIVE;
          end
        end
        SFPST_ST_BUSY, SFPST_ST_ENTER_ULTRA, SFPST_ST_RESUME: begin
          if (tmr_q <= sfpst_cnt_t'(1)) begin
            state_q <= (state_q == SFPST_ST_ENTER_ULTRA) ? SFPST_ST_ULTRA
                       : SFPST_ST_STANDBY;
            tmr_q <= '0;
          end else begin
            tmr_q <= tmr_q - sfpst_cnt_t'(1);
          end
        end
        SFPST_ST_ULTRA: begin
          // any low pulse on chip select wakes; the synchroniser already
          // samples every pulse longer than one clock, which is below the 20 ns minimum
          if (cs_fall) begin
            state_q <= SFPST_ST_EXIT_ULTRA;
            tmr_q <= EXIT_CYC;
          end
        end
        SFPST_ST_EXIT_ULTRA: begin
          if (tmr_q <= sfpst_cnt_t'(1)) begin
            state_q <= SFPST_ST_STANDBY;
            tmr_q <= '0;
          end else begin
            tmr_q <= tmr_q - sfpst_cnt_t'(1);
          end
        end
        default: begin
          state_q <= SFPST_ST_POR;
          tmr_q <= '0;
        end
      endcase
    end
  end
  assign state = state_q;
  assign busy = (state_q == SFPST_ST_BUSY);
  assign cmd_accept = accept_now;

  // ----------------------------------------------------------------
  // serial output enable: never drives during reset or power states
  // ----------------------------------------------------------------
  logic so_oe_q;
  always_ff @(posedge mclk) begin
    if (srst) begin
      so_oe_q <= 1'b0;
    end else begin
      so_oe_q <= so_drive_req & ~cs_s_q & armed_q & (cmd_is_read ? rd_done_q : 1'b1);
    end
  end
  assign so_oe = so_oe_q;

endmodule

/* File: sim/sfpst_checker.sv */
// port checker for the power-state sequencer
`timescale 1ns/100ps
module sfpst_checker
  import sfpst_pkg::*;
#(
  parameter sfpst_cnt_t ENTRY_CYC = 20,
  parameter sfpst_cnt_t EXIT_CYC = 20,
  parameter sfpst_cnt_t RESUME_CYC = 20
) (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // watched ports
  input wire logic chip_select_n,
  input wire logic so_oe,
  input wire sfpst_op_e cmd_op,
  input wire sfpst_state_e state,
  input wire logic spi_mode3,
  input wire logic cmd_accept,
  input wire logic busy,
  input wire logic write_allowed
);
  localparam int EN_MAX = ENTRY_CYC + 2;
  localparam int EX_MAX = EXIT_CYC + 2;
  localparam int RS_MAX = RESUME_CYC + 2;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // dwell counter: recovery and resume outlast any delay range
  sfpst_state_e prev_q;
  sfpst_cnt_t dwell_q;
  always_ff @(posedge mclk) begin
    prev_q <= state;
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      dwell_q <= '0;
    end else if (state == prev_q) begin
      dwell_q <= dwell_q + sfpst_cnt_t'(1);
    end else begin
      dwell_q <= '0;
    end
  end
  // ----------------------------
  // timing checks
  // ----------------------------
  sequence cfg_done;
    busy ##[1:51] !busy;
  endsequence
  so_hiz_a: assert property ($fell(srst) |-> !so_oe)
    else $error("data out driven after reset");
  por_quiet_a: assert property (state == SFPST_ST_POR |-> !cmd_accept && !busy)
    else $error("activity during power-on reset");
  mode_pick_a: assert property ($changed(spi_mode3) && !$past(srst) |-> !$past(chip_select_n, 2))
    else $error("mode changed without chip select fall");
  entry_time_a: assert property ($rose(state == SFPST_ST_ENTER_ULTRA) |-> ##[1:EN_MAX] state == SFPST_ST_ULTRA)
    else $error("ultra sleep entry too slow");
  exit_time_a: assert property (state == SFPST_ST_EXIT_ULTRA |-> !cmd_accept && dwell_q <= EX_MAX)
    else $error("wake recovery wrong");
  resume_time_a: assert property (state == SFPST_ST_RESUME |-> dwell_q <= RS_MAX)
    else $error("resume too slow");
  cfg_write_a: assert property (cmd_accept && write_allowed && cmd_op == SFPST_OP_CFG_WRITE |=> cfg_done)
    else $error("config write time wrong");
  write_lock_a: assert property (busy |-> write_allowed)
    else $error("busy before power-up delay");
  standby_entry_a: assert property ($rose(write_allowed) && chip_select_n |-> ##[0:2] state == SFPST_ST_STANDBY)
    else $error("not standby after power-up");
  busy_hold_a: assert property ($rose(busy) |-> busy [*8])
    else $error("busy period cut short");
endmodule

/* File: sim/sfpst_host_model.sv */
// host link model: drives chip select and the serial clock
`timescale 1ns/100ps
module sfpst_host_model (
  // link pins
  output logic chip_select_n,
  output logic sclk,
  // timing reference
  input wire logic mclk
);
  initial begin
    chip_select_n = 1'h1;
    sclk = 1'h0;
  end
  // clock rests at its idle level outside frames; that level picks the mode
  task automatic frame(input logic idle, input int ntog);
    sclk = idle;
    repeat (3) @(negedge mclk);
    chip_select_n = 1'h0;
    repeat (8) @(negedge mclk);
    repeat (ntog) #62.5 sclk = ~sclk;
    @(negedge mclk);
    chip_select_n = 1'h1;
  endtask
endmodule

/* File: sim/tb_top.sv */
// self-checking bench for the power-state sequencer
`timescale 1ns/100ps
`include "sfpst_regs.svh"
module tb_top
  import sfpst_pkg::*;
;
  logic mclk = 1'h0;
  logic srst = 1'h1;
  logic so_drive_req = 1'h0;
  logic cmd_valid = 1'h0;
  sfpst_op_e cmd_op = SFPST_OP_NONE;
  logic cmd_ultra_sleep = 1'h0;
  logic cmd_is_read = 1'h0;
  wire chip_select_n;
  wire sclk;
  logic so_oe, spi_mode3, cmd_accept, busy, read_allowed, write_allowed;
  sfpst_state_e state;
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int n_acc = 0;
  int n;
  int exp_q[$];
  logic [31:0] rng = 32'h9F358921;
  always #2 mclk = ~mclk;
  sfpst_host_model u_host (.chip_select_n(chip_select_n), .sclk(sclk), .mclk(mclk));
  // mid-length counts are shortened to 20; block and chip erase and the power-state timers run at full length
  sfpst_core #(.OTP_CYC(20), .READ_LOCK_CYC(20), .PUW_CYC(20), .PP_CYC(20), .PE_CYC(20))
  u_dut (.mclk(mclk), .srst(srst), .chip_select_n(chip_select_n), .sclk(sclk),
    .so_drive_req(so_drive_req), .so_oe(so_oe), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_ultra_sleep(cmd_ultra_sleep), .cmd_is_read(cmd_is_read), .state(state),
    .spi_mode3(spi_mode3), .cmd_accept(cmd_accept), .busy(busy),
    .read_allowed(read_allowed), .write_allowed(write_allowed));
  // ----------------------------
  // helpers
  // ----------------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] r;
    r = v ^ (v << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction
  task automatic chk_v(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_n(input string nm, input int e, input int g);
    n_compared++;
    if (g != e) begin
      num_errors++;
      $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic close_out();
    if (num_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // one frame, then the decoded command; counts cycles spent busy or resuming
  task automatic reboot();
    srst = 1'h1;
    repeat (2) @(negedge mclk);
    chk_v("state", SFPST_ST_POR, state);
    chk_v("so_oe", 1'h0, so_oe);
    srst = 1'h0;
    repeat (30) @(negedge mclk);
  endtask
  task automatic send(input sfpst_op_e op, input logic ultra, input int lim, output int cnt);
    rng = xs(rng);
    u_host.frame(rng[0], 4);
    chk_v("mode", rng[0], spi_mode3);
    @(negedge mclk);
    cmd_op = op;
    cmd_ultra_sleep = ultra;
    cmd_is_read = (op == SFPST_OP_NONE);
    so_drive_req = rng[1];
    cmd_valid = 1'h1;
    cnt = 0;
    for (int i = 0; i < lim; i++) begin
      @(negedge mclk);
      if (i == 4) cmd_valid = 1'h0;
      if (state === SFPST_ST_BUSY || state === SFPST_ST_RESUME) cnt++;
    end
  endtask
  always @(posedge mclk) begin
    if (cmd_accept === 1'h1) n_acc <= n_acc + 1;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors++;
      close_out();
    end
  end
  initial begin
    repeat (12) @(negedge mclk);
    chk_v("so_oe", 1'h0, so_oe);
    srst = 1'h0;
    send(SFPST_OP_PAGE_PROG, 1'h0, 130, n);
    chk_n("accepts", 0, n_acc);
    chk_v("state", SFPST_ST_STANDBY, state);
    chk_v("read_ok", 1'h1, read_allowed);
    for (int k = 1; k < 8; k++) begin
      // block and chip erase outlast the run: watch 129 busy cycles, then reset mid-run
      exp_q.push_back(k == 7 ? int'(`SFPST_RESUME_CYC) : k == 6 ? int'(`SFPST_CFGW_CYC)
        : (k == 3 || k == 4) ? 129 : 20);
      send(sfpst_op_e'(k), 1'h0, k == 7 ? 2100 : 130, n);
      chk_n("op_len", exp_q.pop_front(), n);
      if (k == 3 || k == 4) reboot();
    end
    chk_n("accepts", 7, n_acc);
    send(SFPST_OP_NONE, 1'h1, 800, n);
    chk_v("state", SFPST_ST_ULTRA, state);
    u_host.frame(1'h0, 0);
    chk_v("state", SFPST_ST_EXIT_ULTRA, state);
    send(SFPST_OP_PAGE_PROG, 1'h0, 130, n);
    chk_n("accepts", 8, n_acc);
    repeat (int'(`SFPST_EXIT_CYC)) @(negedge mclk);
    chk_v("state", SFPST_ST_STANDBY, state);
    send(SFPST_OP_PAGE_PROG, 1'h0, 130, n);
    chk_n("op_len", 20, n);
    chk_n("accepts", 9, n_acc);
    reboot();
    close_out();
  end
endmodule
bind sfpst_core sfpst_checker #(.ENTRY_CYC(ENTRY_CYC), .EXIT_CYC(EXIT_CYC),
  .RESUME_CYC(RESUME_CYC)) u_chk (.mclk(mclk), .srst(srst), .chip_select_n(chip_select_n),
  .so_oe(so_oe), .cmd_op(cmd_op), .state(state), .spi_mode3(spi_mode3),
  .cmd_accept(cmd_accept), .busy(busy), .write_allowed(write_allowed));
